// >>> src/wake_seq_pkg.sv
// constants shared by the edge-wake power sequencer and its serial write port
// assumes a 50 MHz system clock; all timing counts derive from it
package wake_seq_pkg;
  localparam int          CLK_HZ             = 50_000_000;
  localparam int          SHUTDOWN_DELAY_MS  = 2000;
  localparam int          SHUTDOWN_DELAY_CYC = CLK_HZ / 1000 * SHUTDOWN_DELAY_MS;
  localparam int          WDOG_TIMEOUT_MS    = 1600;
  localparam int          WDOG_TIMEOUT_CYC   = CLK_HZ / 1000 * WDOG_TIMEOUT_MS;
  localparam int          RESET_PULSE_US     = 200;
  localparam int          RESET_PULSE_CYC    = CLK_HZ / 1_000_000 * RESET_PULSE_US;
  localparam logic [5:0]  DEV_ADDR_HI        = 6'h17;
  localparam logic [7:0]  PTR_HV_TWO_OFF     = 8'h04;
  localparam logic [7:0]  HV_TWO_OFF_EDGE    = 8'h09;
  localparam logic [3:0]  HV_TWO_OFF_RESET   = 4'h0;
  localparam logic [6:0]  PTR_FIELD_MASK     = 7'h7f;
  localparam int          CNT_W              = 32;
endpackage

// >>> src/ser_write_if.sv
// carries decoded register writes from the serial port to the sequencer core
// assumes a single clock domain shared by both ends
interface ser_write_if;
  logic       wr_stb;
  logic [6:0] wr_ptr;
  logic [7:0] wr_data;
  modport src (output wr_stb, output wr_ptr, output wr_data);
  modport dst (input wr_stb, input wr_ptr, input wr_data);
endinterface

// >>> src/ser_write_port.sv
// two-wire serial slave: write transactions only; pointer byte then data byte
// assumes SCL and SDA already synchronous to MCLK; SDA driven only as open drain
module ser_write_port (
  input  wire logic clk,           // system clock
  input  wire logic rst_n,         // sync reset, active low
  input  wire logic ce,            // clock enable
  input  wire logic scl,           // serial clock level
  input  wire logic sda_in,        // serial data level
  input  wire logic addr_sel,      // address select strap
  output logic      sda_oe_n,      // low while pulling sda low
  ser_write_if.src  wr             // decoded write
);
  typedef enum logic [3:0] {S_IDLE = 4'h1, S_ADDR = 4'h2, S_PTR = 4'h4, S_DATA = 4'h8} st_type;
  st_type     st_q, st_d;
  logic       scl_q, sda_q;
  logic [7:0] sh_q, sh_d;
  logic [3:0] bit_q, bit_d;
  logic       ack_q, ack_d;
  logic [6:0] ptr_q, ptr_d;
  logic       stb_d, stb_q;
  logic [7:0] dat_q, dat_d;
  wire start = scl && scl_q && sda_q && !sda_in;
  wire stop  = scl && scl_q && !sda_q && sda_in;
  wire rise  = scl && !scl_q;
  wire fall  = !scl && scl_q;

  always_comb begin
    st_d  = st_q;
    sh_d  = sh_q;
    bit_d = bit_q;
    ack_d = ack_q;
    ptr_d = ptr_q;
    stb_d = 1'b0;
    dat_d = dat_q;
    if (start) begin
      st_d  = S_ADDR;
      bit_d = 4'h0;
      ack_d = 1'b0;
    end else if (stop) begin
      st_d  = S_IDLE;
      ack_d = 1'b0;
    end else if (st_q != S_IDLE) begin
      if (rise && bit_q < 4'h8) begin
        sh_d  = {sh_q[6:0], sda_in};
        bit_d = bit_q + 4'h1;
      end else if (fall && bit_q == 4'h8 && !ack_q) begin
        case (st_q)
          S_ADDR: begin
            // six fixed bits plus strap, write only
            if (sh_q == {wake_seq_pkg::DEV_ADDR_HI, addr_sel, 1'b0}) begin
              ack_d = 1'b1;
              st_d  = S_PTR;
            end else begin
              st_d = S_IDLE;
            end
          end
          S_PTR: begin
            ptr_d = sh_q[6:0] & wake_seq_pkg::PTR_FIELD_MASK;
            ack_d = 1'b1;
            st_d  = S_DATA;
          end
          S_DATA: begin
            dat_d = sh_q;
            stb_d = 1'b1;
            ack_d = 1'b1;
          end
          default: begin
            st_d = S_IDLE;
          end
        endcase
      end else if (fall && ack_q) begin
        ack_d = 1'b0;
        bit_d = 4'h0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q  <= S_IDLE;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      sh_q  <= 8'h00;
      bit_q <= 4'h0;
      ack_q <= 1'b0;
      ptr_q <= 7'h00;
      stb_q <= 1'b0;
      dat_q <= 8'h00;
    end else if (ce) begin
      st_q  <= st_d;
      scl_q <= scl;
      sda_q <= sda_in;
      sh_q  <= sh_d;
      bit_q <= bit_d;
      ack_q <= ack_d;
      ptr_q <= ptr_d;
      stb_q <= stb_d;
      dat_q <= dat_d;
    end
  end

  assign sda_oe_n   = !ack_q;
  assign wr.wr_stb  = stb_q & ce;
  assign wr.wr_ptr  = ptr_q;
  assign wr.wr_data = dat_q;
endmodule

// >>> src/edge_wake_power_sequencer.sv
// edge-triggered wake and watchdog-governed power-down sequencer
// assumes all pins synchronous to MCLK; host drives the serial port
// Function
// - rising edge on monitor two wakes device and raises power enable
// - without watchdog activity after wake, reset pulses repeat until activity
// - power enable stays high while correct watchdog activity arrives
// - loss of watchdog activity asserts reset
// - two seconds after that reset, power enable drops low
// - then device sleeps awaiting next rising wake edge
// - first write byte loads pointer, second byte goes to selected register
module edge_wake_power_sequencer #(
  parameter int POWER_ENABLE_N_CYC  = wake_seq_pkg::SHUTDOWN_DELAY_CYC,
  parameter int WDOG_CYC  = wake_seq_pkg::WDOG_TIMEOUT_CYC,
  parameter int PULSE_CYC = wake_seq_pkg::RESET_PULSE_CYC
) (
  input  wire logic MCLK,            // system clock
  input  wire logic RST_N,           // sync reset, active low
  input  wire logic CE,              // clock enable
  input  wire logic SCL,             // serial clock
  input  wire logic SDA_IN,          // serial data in
  output logic      SDA_OE_N,        // serial data pull, low drives
  input  wire logic ADDRESS_SELECT_PIN, // address low bit strap
  input  wire logic HV_MONITOR_TWO_INPUT, // wake monitor level
  input  wire logic WATCHDOG_INPUT,  // watchdog kick
  output logic      POWER_ENABLE_N,  // regulator enable, high on
  output logic      RESET_N,         // processor reset, active low
  output logic      EDGE_MODE        // edge wake mode selected
);
  if (POWER_ENABLE_N_CYC < 1 || WDOG_CYC < 1 || PULSE_CYC < 1) begin : g_count_check
    $error("counts must be positive");
  end

  typedef enum logic [4:0] {
    S_SLEEP = 5'h01, S_PULSE = 5'h02, S_RUN = 5'h04, S_LOSS = 5'h08, S_OFF = 5'h10
  } st_type;

  ser_write_if wr ();
  ser_write_port u_port (
    .clk      (MCLK),
    .rst_n    (RST_N),
    .ce       (CE),
    .scl      (SCL),
    .sda_in   (SDA_IN),
    .addr_sel (ADDRESS_SELECT_PIN),
    .sda_oe_n (SDA_OE_N),
    .wr       (wr)
  );

  st_type      st_q, st_d;
  logic [3:0]  off_set_q, off_set_d;
  logic        mon_q, mon_d;
  logic        wdi_q, wdi_d;
  logic [31:0] cnt_q, cnt_d;
  logic [31:0] wd_q, wd_d;
  logic        pen_q, pen_d;
  logic        rst_q, rst_d;

  // true on the last cycle of a span of lim cycles
  function automatic logic reached(input logic [31:0] cnt, input int lim);
    return cnt >= 32'(lim - 1);
  endfunction

  wire edge_mode = ({4'h0, off_set_q} == wake_seq_pkg::HV_TWO_OFF_EDGE);
  wire wake_edge = HV_MONITOR_TWO_INPUT && !mon_q;
  wire wd_edge   = WATCHDOG_INPUT != wdi_q;
  wire wd_expire = reached(wd_q, WDOG_CYC);

  // mode register: only the monitor-two turn-off setting is kept, low four bits
  always_comb begin
    off_set_d = off_set_q;
    if (wr.wr_stb && {1'b0, wr.wr_ptr} == wake_seq_pkg::PTR_HV_TWO_OFF) begin
      off_set_d = wr.wr_data[3:0];
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      off_set_q <= wake_seq_pkg::HV_TWO_OFF_RESET;
    end else if (CE) begin
      off_set_q <= off_set_d;
    end
  end

  // previous pin levels for the wake and watchdog edge detectors
  always_comb begin
    mon_d = HV_MONITOR_TWO_INPUT;
    wdi_d = WATCHDOG_INPUT;
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      mon_q <= 1'b0;
      wdi_q <= 1'b0;
    end else if (CE) begin
      mon_q <= mon_d;
      wdi_q <= wdi_d;
    end
  end

  always_comb begin
    st_d  = st_q;
    cnt_d = cnt_q;
    pen_d = pen_q;
    rst_d = rst_q;
    // any watchdog edge restarts the timeout window
    wd_d  = (wd_edge || wd_expire) ? 32'h0000_0000 : wd_q + 32'h0000_0001;
    case (st_q)
      S_SLEEP: begin
        pen_d = 1'b0;
        rst_d = 1'b0;
        if (edge_mode && wake_edge) begin
          st_d  = S_PULSE;
          pen_d = 1'b1;
          cnt_d = 32'h0000_0000;
          wd_d  = 32'h0000_0000;
        end
      end
      S_PULSE: begin
        cnt_d = cnt_q + 32'h0000_0001;
        if (wd_edge) begin
          st_d  = S_RUN;
          rst_d = 1'b1;
        end else if (!rst_q && reached(cnt_q, PULSE_CYC)) begin
          rst_d = 1'b1;
          cnt_d = 32'h0000_0000;
        end else if (rst_q && reached(cnt_q, WDOG_CYC)) begin
          rst_d = 1'b0;
          cnt_d = 32'h0000_0000;
        end
      end
      S_RUN: begin
        pen_d = 1'b1;
        if (!wd_edge && wd_expire) begin
          st_d  = S_LOSS;
          rst_d = 1'b0;
          cnt_d = 32'h0000_0000;
        end
      end
      S_LOSS: begin
        cnt_d = cnt_q + 32'h0000_0001;
        if (reached(cnt_q, POWER_ENABLE_N_CYC)) begin
          st_d  = S_OFF;
          pen_d = 1'b0;
        end
      end
      S_OFF: begin
        st_d = S_SLEEP;
      end
      default: begin
        st_d = S_SLEEP;
      end
    endcase
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      st_q  <= S_SLEEP;
      cnt_q <= 32'h0000_0000;
      wd_q  <= 32'h0000_0000;
      pen_q <= 1'b0;
      rst_q <= 1'b0;
    end else if (CE) begin
      st_q  <= st_d;
      cnt_q <= cnt_d;
      wd_q  <= wd_d;
      pen_q <= pen_d;
      rst_q <= rst_d;
    end
  end

  assign POWER_ENABLE_N = pen_q;
  assign RESET_N        = rst_q;
  assign EDGE_MODE      = edge_mode;

  wake_raise_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    CE && st_q == S_SLEEP && edge_mode && wake_edge |=> POWER_ENABLE_N)
    else $error("wake edge did not raise power enable");
  run_hold_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    st_q == S_RUN |-> POWER_ENABLE_N)
    else $error("power enable low while serviced");
  loss_reset_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    $rose(st_q == S_LOSS) |-> !RESET_N)
    else $error("no reset on watchdog loss");
  loss_off_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    st_q == S_LOSS && CE && cnt_q >= 32'(POWER_ENABLE_N_CYC - 1) |=> !POWER_ENABLE_N)
    else $error("power enable not dropped after delay");
  loss_hold_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    st_q == S_LOSS |-> POWER_ENABLE_N)
    else $error("power enable dropped early");
  off_sleep_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    st_q == S_OFF && CE |=> st_q == S_SLEEP && !POWER_ENABLE_N)
    else $error("did not sleep after power off");
  pulse_exit_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    st_q == S_PULSE && CE && wd_edge |=> st_q == S_RUN && RESET_N)
    else $error("pulse train did not end on watchdog");
  mode_write_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    CE && wr.wr_stb && {1'b0, wr.wr_ptr} == wake_seq_pkg::PTR_HV_TWO_OFF
    && wr.wr_data == wake_seq_pkg::HV_TWO_OFF_EDGE |=> EDGE_MODE)
    else $error("mode write not taken");
  sleep_quiet_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    st_q == S_SLEEP && !(edge_mode && wake_edge) && CE |=> !POWER_ENABLE_N)
    else $error("power enable high in sleep");
  pulse_release_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    st_q == S_PULSE && CE && !wd_edge && !rst_q && reached(cnt_q, PULSE_CYC) |=> RESET_N)
    else $error("reset pulse did not end");
  pulse_repeat_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    st_q == S_PULSE && CE && !wd_edge && rst_q && reached(cnt_q, WDOG_CYC) |=> !RESET_N)
    else $error("reset pulse did not repeat");
  pulse_power_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    st_q == S_PULSE |-> POWER_ENABLE_N)
    else $error("power enable low during pulses");
  kick_keep_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    st_q == S_RUN && CE && wd_edge |=> st_q == S_RUN && RESET_N && POWER_ENABLE_N)
    else $error("serviced watchdog left run");
  run_loss_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    st_q == S_RUN && CE && !wd_edge && wd_expire |=> st_q == S_LOSS && !RESET_N)
    else $error("watchdog loss not taken");
  mode_hold_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    !(CE && wr.wr_stb) |=> $stable(EDGE_MODE))
    else $error("mode changed without write");
  wake_c: cover property (@(posedge MCLK) st_q == S_SLEEP ##1 st_q == S_PULSE);
  run_c: cover property (@(posedge MCLK) st_q == S_PULSE ##1 st_q == S_RUN);
  off_c: cover property (@(posedge MCLK) st_q == S_OFF);
  pulse_c: cover property (@(posedge MCLK) st_q == S_PULSE && $rose(RESET_N));
  loss_c: cover property (@(posedge MCLK) st_q == S_RUN ##1 st_q == S_LOSS);
endmodule

// >>> dv/host_model.sv
// host side model: serial write master and watchdog kicker
// assumes sda is the open-drain line with a pull-up, resolved outside
module host_model (
  input  wire logic clk,    // system clock
  input  wire logic sda,    // resolved data line
  output logic      scl,    // serial clock
  output logic      sda_o,  // data drive, 1 releases
  output logic      watchdog_input     // watchdog line
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    scl = 1'b1;
    sda_o = 1'b1;
    watchdog_input = 1'b0;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // eight bits msb first, then ack sampled while scl is high
  task automatic send(input logic [7:0] b, output logic ack);
    for (int i = 8; i >= 0; i--) begin
      hold(2);
      sda_o = (i == 0) ? 1'b1 : b[i-1];
      hold(2);
      scl = 1'b1;
      hold(4);
      if (i == 0) ack = ~sda;
      scl = 1'b0;
    end
  endtask
  // start, address with write bit, pointer, data, stop
  task automatic write(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d, output logic [2:0] acks);
    hold(4);
    sda_o = 1'b0;
    hold(4);
    scl = 1'b0;
    send({a, 1'b0}, acks[2]);
    send(p, acks[1]);
    send(d, acks[0]);
    hold(2);
    sda_o = 1'b0;
    hold(2);
    scl = 1'b1;
    hold(4);
    sda_o = 1'b1;
  endtask
  // one edge is one kick; stopping kicks asks for power down
  task automatic kick;
    watchdog_input = ~watchdog_input;
  endtask
endmodule

// >>> dv/edge_wake_power_sequencer_tb.sv
// self-checking bench for the edge-wake sequencer with short counts
// assumes host_model drives the serial lines and the watchdog
module edge_wake_power_sequencer_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int SHD = 50;
  localparam int WDG = 20;
  localparam int PUL = 4;
  logic       mclk  = 1'b0;
  logic       rst_n = 1'b0;
  logic       mon   = 1'b0;
  logic       asel  = 1'b1;
  logic       ce    = 1'b1;
  logic       scl, sda_o, watchdog_input, oe_n, pen_n, rst_out_n, edge_mode;
  wire        sda   = sda_o & oe_n;
  logic [2:0] acks;
  int         fail_count = 0;
  int         comparisons = 0;
  int         n;
  always #10 mclk = ~mclk;
  edge_wake_power_sequencer #(.POWER_ENABLE_N_CYC(SHD), .WDOG_CYC(WDG), .PULSE_CYC(PUL)) dut (
    .MCLK(mclk), .RST_N(rst_n), .CE(ce), .SCL(scl), .SDA_IN(sda), .SDA_OE_N(oe_n),
    .ADDRESS_SELECT_PIN(asel), .HV_MONITOR_TWO_INPUT(mon), .WATCHDOG_INPUT(watchdog_input),
    .POWER_ENABLE_N(pen_n), .RESET_N(rst_out_n), .EDGE_MODE(edge_mode));
  host_model host (.clk(mclk), .sda(sda), .scl(scl), .sda_o(sda_o), .watchdog_input(watchdog_input));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic step(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask
  task automatic finish_test;
    $display("mismatches=%0d comparisons=%0d", fail_count, comparisons);
    if (fail_count == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // cycles until the chosen output goes low, 0 if it does not within 200 cycles
  task automatic to_low(input bit pick, output int c);
    c = 0;
    for (int i = 1; i <= 200 && c == 0; i++) begin
      step(1);
      if ((pick ? pen_n : rst_out_n) === 1'b0) c = i;
    end
  endtask
  task automatic t_setup;
    check({pen_n, rst_out_n, edge_mode, oe_n}, 4'h1);
    mon = 1'b1;
    step(10);
    check(pen_n, 1'b0);
    mon = 1'b0;
    host.write({6'h17, ~asel}, 8'h04, 8'h09, acks);
    check(acks, 3'h0);
    check(edge_mode, 1'b0);
    host.write({6'h17, asel}, 8'h04, 8'h00, acks);
    check({acks, edge_mode}, 4'he);
    host.write({6'h17, asel}, 8'h04, 8'h09, acks);
    check({acks, edge_mode}, 4'hf);
  endtask
  task automatic t_wake;
    int   rises;
    logic prev;
    rises = 0;
    mon = 1'b1;
    step(2);
    check({pen_n, rst_out_n}, 2'h2);
    prev = rst_out_n;
    for (int i = 0; i < 60; i++) begin
      step(1);
      if (rst_out_n === 1'b1 && prev === 1'b0) rises++;
      prev = rst_out_n;
      check(pen_n, 1'b1);
    end
    check(rises >= 2, 1'b1);
  endtask
  task automatic t_run_down;
    for (int i = 0; i < 10; i++) begin
      host.kick;
      step(10);
      check({pen_n, rst_out_n}, 2'h3);
    end
    // clock enable low freezes the watchdog timeout as well
    ce = 1'b0;
    step(3 * WDG);
    check({pen_n, rst_out_n}, 2'h3);
    ce = 1'b1;
    host.kick;
    to_low(1'b0, n);
    check(n >= WDG - 1 && n <= WDG + 2, 1'b1);
    to_low(1'b1, n);
    check(n >= SHD - 2 && n <= SHD + 2, 1'b1);
    step(30);
    check({pen_n, rst_out_n}, 2'h0);
    mon = 1'b0;
    step(4);
    mon = 1'b1;
    step(3);
    check(pen_n, 1'b1);
  endtask
  initial begin
    step(5);
    rst_n = 1'b1;
    step(2);
    t_setup;
    t_wake;
    t_run_down;
    finish_test;
  end
  initial begin
    #400_000;
    fail_count++;
    finish_test;
  end
endmodule
